// ### rtl/bcs_pkg.sv
// Shared constants and state encoding for the serial position frame slave.
package bcs_pkg;
  // Resolution range of the absolute position field, in bits.
  localparam int RES_MIN = 17;
  localparam int RES_MAX = 20;
  localparam int RES_DEFAULT = 20;
  // Bits that follow the position field: error, warning and check sum.
  localparam int TAIL_BITS = 8;
  localparam int CRC_W = 6;
  // Generator x^6 + x + 1, with the x^6 term implied.
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [5:0] CRC_INIT = 6'h00;
  // Fixed line levels of the frame.
  localparam logic LVL_IDLE = 1'h1;
  localparam logic LVL_ACK = 1'h0;
  localparam logic LVL_START = 1'h1;
  localparam logic LVL_ZERO = 1'h0;
  localparam logic LVL_BUSY = 1'h0;
  localparam logic WARN_LEVEL = 1'h1;
  localparam logic ERR_NO_TEST = 1'h1;
  // Request spacing, 25 us, and the system clock period.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMEOUT_NS = 25000;
  // A least time rounds up to whole cycles.
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOC_W = $clog2(TIMEOUT_CYC + 1);
  // Depth of the position word buffer.
  localparam int BUF_DEPTH = 2;

  typedef enum logic [5:0] {
    BCS_IDLE    = 6'h01,
    BCS_ACK     = 6'h02,
    BCS_START   = 6'h04,
    BCS_ZERO    = 6'h08,
    BCS_DATA    = 6'h10,
    BCS_TIMEOUT = 6'h20
  } bcs_state_e;
endpackage

// ### rtl/bcs_word_if.sv
// Valid and ready handshake that carries position words between buffer and frame engine.
`timescale 1ns/1ns
interface bcs_word_if #(
  parameter int W = 21
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface

// ### rtl/bcs_word_buf.sv
// Small first-in first-out buffer for position words with registered flags.
`timescale 1ns/1ns
module bcs_word_buf #(
  parameter int W = 21,
  parameter int DEPTH = bcs_pkg::BUF_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  bcs_word_if.prod out
);
  import bcs_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  // Flags are decoded from next_count so the filling side sees an honest full.
  assign push = in_valid_i && in_ready_o;
  assign pop = out.valid && out.ready;
  assign out.data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  // Storage array; written only while there is room.
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap at the configured depth, which need not be a power of two.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PW'(1);
      end
    end
  end

  // Count and both flags are registered.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= '0;
      in_ready_o <= 1'h1;
      out.valid <= 1'h0;
    end else begin
      count <= next_count;
      in_ready_o <= (next_count != FULL_CNT);
      out.valid <= (next_count != '0);
    end
  end
endmodule

// ### rtl/bcs_frame_slave.sv
// Serial absolute position frame slave clocked by the controller's link clock.
// How it works
// - Controller supplies link clock; we only drive the data line, one bit per clock.
// - Frame opens with one clock of acknowledge, data held low.
// - Acknowledge is followed by a start bit of one then a zero bit.
// - Position field width is the resolution, 17 to 20 bits, above error.
// - Error bit sits at position 7, warning at 6, warning always one.
// - With built-in test, error bit is one when healthy, zero on fault.
// - Without built-in test the error bit is always sent as one.
// - Six-bit check x^6+x+1 over position, error, warning, at positions 5..0.
// - Check sum goes out most significant bit first, every bit inverted.
// - Start and zero bits never enter the check sum.
// - Twenty-five microseconds of quiet clock separate two requests.
// - Service mode reuses pairs: clock pair receives, data pair transmits.
// - After reset the block runs in position mode, not service mode.
`timescale 1ns/1ns
module bcs_frame_slave #(
  parameter int RES_BITS = bcs_pkg::RES_DEFAULT,
  parameter bit HAS_SELF_TEST = 1'b1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  output logic link_data_o,
  input wire logic pos_valid_i,
  input wire logic [RES_BITS-1:0] pos_data_i,
  output logic pos_ready_o,
  input wire logic health_ok_i,
  input wire logic setup_mode_i,
  input wire logic svc_tx_i,
  output logic svc_rx_o,
  output logic frame_busy_o
);
  import bcs_pkg::*;

  localparam int WORD_W = RES_BITS + 1;
  localparam int SH_W = RES_BITS + 2;
  localparam int FRAME_BITS = RES_BITS + TAIL_BITS;
  localparam int CNT_W = $clog2(FRAME_BITS + 1);
  localparam logic [CNT_W-1:0] FRAME_LEN = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] CRC_LEN = CNT_W'(CRC_W);
  localparam logic [TOC_W-1:0] TOC_LIMIT = TOC_W'(TIMEOUT_CYC - 1);

  // One step of the serial check sum, most significant bit first.
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] crc, input logic din);
    logic fb;
    fb = crc[CRC_W-1] ^ din;
    crc_step = {crc[CRC_W-2:0], 1'h0} ^ (fb ? CRC_POLY : CRC_INIT);
  endfunction

  // Error bit that goes into the frame for the current health level.
  function automatic logic err_level(input logic healthy);
    err_level = HAS_SELF_TEST ? healthy : ERR_NO_TEST;
  endfunction

  bcs_word_if #(.W(WORD_W)) word_q ();

  // Position words wait here; a controller that reads slowly stalls the source.
  bcs_word_buf #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(pos_valid_i),
    .in_data_i({pos_data_i, 1'h0}),
    .in_ready_o(pos_ready_o),
    .out(word_q.prod)
  );

  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic clk_rise;
  logic clk_edge;
  logic [TOC_W-1:0] quiet_cnt;
  logic timed_out;
  logic svc_mode;
  bcs_state_e state;
  bcs_state_e next_state;
  logic [SH_W-1:0] shifter;
  logic [CRC_W-1:0] crc;
  logic [CNT_W-1:0] bits_left;
  logic [CNT_W-1:0] bits_now;
  logic [RES_BITS-1:0] held_pos;
  logic [RES_BITS-1:0] snap_pos;
  logic tx_bit;
  logic next_data;
  logic take_word;

  // Two flip-flops bring the link clock into the system clock domain.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_meta <= 1'h1;
      clk_sync <= 1'h1;
      clk_prev <= 1'h1;
    end else begin
      clk_meta <= link_clk_i;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // Data moves on the rising link clock edge; any edge restarts the quiet count.
  assign clk_rise = clk_sync && !clk_prev;
  assign clk_edge = clk_sync ^ clk_prev;

  // Quiet time since the last link clock edge, saturating at the limit.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quiet_cnt <= '0;
    end else if (clk_edge) begin
      quiet_cnt <= '0;
    end else if (quiet_cnt != TOC_LIMIT) begin
      quiet_cnt <= quiet_cnt + TOC_W'(1);
    end
  end

  // Only a clock held still for the whole interval ends the busy period.
  assign timed_out = (quiet_cnt == TOC_LIMIT) && !clk_edge;

  // Mode changes wait for an idle line, so only a frame that starts in that same cycle can be cut.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      svc_mode <= 1'h0;
    end else if (state == BCS_IDLE) begin
      svc_mode <= setup_mode_i;
    end
  end

  // Frame sequencer.
  always_comb begin
    next_state = state;
    case (state)
      BCS_IDLE: begin
        if (clk_rise && !svc_mode) begin
          next_state = BCS_ACK;
        end
      end
      BCS_ACK: begin
        if (clk_rise) begin
          next_state = BCS_START;
        end
      end
      BCS_START: begin
        if (clk_rise) begin
          next_state = BCS_ZERO;
        end
      end
      BCS_ZERO: begin
        if (clk_rise) begin
          next_state = BCS_DATA;
        end
      end
      BCS_DATA: begin
        if (clk_rise && bits_left == '0) begin
          next_state = BCS_TIMEOUT;
        end
      end
      BCS_TIMEOUT: begin
        if (timed_out) begin
          next_state = BCS_IDLE;
        end
      end
      default: begin
        next_state = BCS_IDLE;
      end
    endcase
    // A controller that stops mid-frame gets the line back after the same interval.
    if (timed_out && state != BCS_IDLE) begin
      next_state = BCS_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= BCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // A fresh word is taken at the acknowledge; with none waiting the last one repeats.
  assign take_word = (state == BCS_IDLE) && (next_state == BCS_ACK);
  assign word_q.ready = take_word;
  assign snap_pos = word_q.valid ? word_q.data[WORD_W-1:1] : held_pos;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held_pos <= '0;
    end else if (take_word) begin
      held_pos <= snap_pos;
    end
  end

  // Count of frame bits still to go, counted from the zero bit onward.
  assign bits_now = (state == BCS_ZERO) ? FRAME_LEN : bits_left;
  // Field bits come from the shifter, the check sum goes out inverted.
  assign tx_bit = (bits_now > CRC_LEN) ? shifter[SH_W-1] : ~crc[CRC_W-1];

  // Bit count and check sum advance once per data bit, the shifter once per field bit.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shifter <= '0;
      crc <= CRC_INIT;
      bits_left <= '0;
    end else if (take_word) begin
      shifter <= {snap_pos, err_level(health_ok_i), WARN_LEVEL};
      crc <= CRC_INIT;
    end else if (clk_rise && next_state == BCS_DATA) begin
      bits_left <= bits_now - CNT_W'(1);
      if (bits_now > CRC_LEN) begin
        shifter <= {shifter[SH_W-2:0], 1'h0};
        crc <= crc_step(crc, shifter[SH_W-1]);
      end else begin
        crc <= {crc[CRC_W-2:0], 1'h0};
      end
    end
  end

  // Level of the data pair for the coming state.
  always_comb begin
    next_data = LVL_IDLE;
    if (svc_mode) begin
      next_data = svc_tx_i;
    end else begin
      case (next_state)
        BCS_IDLE: next_data = LVL_IDLE;
        BCS_ACK: next_data = LVL_ACK;
        BCS_START: next_data = LVL_START;
        BCS_ZERO: next_data = LVL_ZERO;
        BCS_DATA: next_data = (clk_rise || state == BCS_DATA) ? (clk_rise ? tx_bit : link_data_o) : LVL_ZERO;
        BCS_TIMEOUT: next_data = LVL_BUSY;
        default: next_data = LVL_IDLE;
      endcase
    end
  end

  // All pin-facing outputs are registered.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_data_o <= LVL_IDLE;
      svc_rx_o <= 1'h1;
      frame_busy_o <= 1'h0;
    end else begin
      link_data_o <= next_data;
      svc_rx_o <= svc_mode ? clk_sync : 1'h1;
      frame_busy_o <= (next_state != BCS_IDLE);
    end
  end
endmodule

// ### tb/bcs_master_model.sv
// Behavioural link controller that clocks position frames out of the slave.
`timescale 1ns/1ns
module bcs_master_model (
  output logic link_clk_o,
  input wire logic link_data_i,
  input wire logic alt_data_i
);
  initial begin
    link_clk_o = 1'h1;
  end

  // Quiet time first, then one bit per 320 ns clock. Each bit is sampled late in the low phase.
  // The slave only moves the line on rises, so late sampling gives the widest settle margin.
  // A second slave on the same clock answers on its own data line, captured at the same instants.
  task automatic read_frame(input int n, output logic [39:0] q, output logic [39:0] q2);
    q = '0;
    q2 = '0;
    #26000;
    link_clk_o = 1'h0;
    #160;
    repeat (n) begin
      link_clk_o = 1'h1;
      #160;
      link_clk_o = 1'h0;
      #150;
      q = {q[38:0], link_data_i};
      q2 = {q2[38:0], alt_data_i};
      #10;
    end
    link_clk_o = 1'h1;
  endtask

  // In service mode the clock pair carries plain receive levels.
  task automatic drive(input logic v);
    link_clk_o = v;
  endtask
endmodule

// ### tb/bcs_frame_slave_sva.sv
// Concurrent checks on the ports of the serial position frame slave.
`timescale 1ns/1ns
module bcs_frame_slave_sva #(
  parameter int RES_BITS = bcs_pkg::RES_DEFAULT,
  parameter bit HAS_SELF_TEST = 1'b1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic link_data_o,
  input wire logic pos_valid_i,
  input wire logic [RES_BITS-1:0] pos_data_i,
  input wire logic pos_ready_o,
  input wire logic health_ok_i,
  input wire logic setup_mode_i,
  input wire logic svc_tx_i,
  input wire logic svc_rx_o,
  input wire logic frame_busy_o
);
  import bcs_pkg::*;
  logic [2:0] sync;
  logic [9:0] quiet;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // Cycles since the last link clock edge; it saturates so long idle spells stay large.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync <= 3'h7;
      quiet <= 10'h000;
    end else begin
      sync <= {sync[1:0], link_clk_i};
      quiet <= (sync[2] ^ sync[1]) ? 10'h000 : quiet + {9'h000, quiet != 10'h3FF};
    end
  end

  sequence ack_s;
    !link_data_o [*3];
  endsequence
  sequence start_s;
    ##[1:12] link_data_o;
  endsequence
  sequence two_push_s;
    (pos_valid_i && pos_ready_o && !frame_busy_o) [*2];
  endsequence

  ack_start_a: assert property ($rose(frame_busy_o) |-> ack_s ##0 start_s)
    else $error("acknowledge or start bit wrong");
  bit_stands_a: assert property (frame_busy_o && $changed(link_data_o) |-> quiet < 10'h008)
    else $error("data moved without a link clock rise");
  busy_end_a: assert property ($fell(frame_busy_o) |-> link_data_o && quiet >= TIMEOUT_CYC - 8)
    else $error("frame ended before the quiet time");
  quiet_end_a: assert property (quiet >= TIMEOUT_CYC + 8 |-> !frame_busy_o)
    else $error("busy past the quiet time");
  buf_full_a: assert property (two_push_s |=> !pos_ready_o || frame_busy_o)
    else $error("ready high with two words stored");
  buf_hold_a: assert property (!pos_ready_o && !frame_busy_o |=> !pos_ready_o || frame_busy_o)
    else $error("ready rose without a frame");
  idle_high_a: assert property ((!setup_mode_i && !frame_busy_o) [*5] |-> link_data_o)
    else $error("idle line not high");
  svc_rx_a: assert property (!setup_mode_i [*5] |-> svc_rx_o)
    else $error("service receive active in position mode");
  svc_tx_a: assert property ((setup_mode_i && !frame_busy_o) [*6] |-> link_data_o == $past(svc_tx_i))
    else $error("service transmit not passed through");
endmodule

bind bcs_frame_slave bcs_frame_slave_sva #(.RES_BITS(RES_BITS), .HAS_SELF_TEST(HAS_SELF_TEST)) chk_u (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i), .link_data_o(link_data_o),
  .pos_valid_i(pos_valid_i), .pos_data_i(pos_data_i), .pos_ready_o(pos_ready_o),
  .health_ok_i(health_ok_i), .setup_mode_i(setup_mode_i), .svc_tx_i(svc_tx_i),
  .svc_rx_o(svc_rx_o), .frame_busy_o(frame_busy_o));

// ### tb/bcs_frame_slave_tb_top.sv
// Self-checking testbench for the serial position frame slave.
`timescale 1ns/1ns
module bcs_frame_slave_tb_top;
  import bcs_pkg::*;
  localparam int RB = 17;
  localparam int NB = RB + 11;
  logic mclk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic pos_valid_i = 1'h0;
  logic health_ok_i = 1'h1;
  logic setup_mode_i = 1'h0;
  logic svc_tx_i = 1'h0;
  logic [RB-1:0] pos_data_i = '0;
  logic [RB-1:0] p;
  logic [31:0] r;
  logic [39:0] q;
  logic [39:0] q2;
  wire link_clk, link_data_o, pos_ready_o, svc_rx_o, frame_busy_o, link_data_nt;
  int n_fail = 0;
  int compares = 0;
  int seed = 32'h10B4;

  bcs_frame_slave #(.RES_BITS(RB), .HAS_SELF_TEST(1'b1)) dut_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .link_clk_i(link_clk), .link_data_o(link_data_o),
    .pos_valid_i(pos_valid_i), .pos_data_i(pos_data_i), .pos_ready_o(pos_ready_o),
    .health_ok_i(health_ok_i), .setup_mode_i(setup_mode_i), .svc_tx_i(svc_tx_i),
    .svc_rx_o(svc_rx_o), .frame_busy_o(frame_busy_o));
  // Same link and source, built without the self test, so its error bit must stay high.
  bcs_frame_slave #(.RES_BITS(RB), .HAS_SELF_TEST(1'b0)) dut_nt_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .link_clk_i(link_clk), .link_data_o(link_data_nt),
    .pos_valid_i(pos_valid_i), .pos_data_i(pos_data_i), .pos_ready_o(),
    .health_ok_i(health_ok_i), .setup_mode_i(setup_mode_i), .svc_tx_i(svc_tx_i),
    .svc_rx_o(), .frame_busy_o());
  bcs_master_model m_u (.link_clk_o(link_clk), .link_data_i(link_data_o), .alt_data_i(link_data_nt));

  // System clock, 40 ns.
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Whole frame as the controller should see it, check sum worked bit by bit.
  function automatic logic [39:0] exp_frame(input logic [RB-1:0] pos, input logic e);
    logic [5:0] c;
    logic [RB+1:0] d;
    c = CRC_INIT;
    d = {pos, e, WARN_LEVEL};
    for (int i = RB + 1; i >= 0; i--) c = {c[4:0], 1'h0} ^ ((d[i] ^ c[5]) ? CRC_POLY : 6'h00);
    return 40'({LVL_ACK, LVL_START, LVL_ZERO, d, ~c});
  endfunction

  // Leaves valid high, so calls in a row offer words back to back.
  task automatic offer(input logic [RB-1:0] w);
    @(negedge mclk_i);
    pos_valid_i = 1'h1;
    pos_data_i = w;
  endtask

  task automatic frame(input logic [RB-1:0] w, input logic e);
    @(negedge mclk_i);
    health_ok_i = e;
    m_u.read_frame(NB, q, q2);
    chk(q, exp_frame(w, e), "frame");
    chk(q2, exp_frame(w, ERR_NO_TEST), "frame without self test");
  endtask

  // Main sequence: reset, full buffer, frames with corner and random positions, service mode.
  initial begin
    repeat (6) @(posedge mclk_i);
    chk(40'({link_data_o, svc_rx_o, frame_busy_o, pos_ready_o}), 40'hD, "reset");
    @(negedge mclk_i);
    nrst_i = 1'h1;
    repeat (4) @(negedge mclk_i);
    r = $random(seed);
    offer(r[RB-1:0]);
    offer(r[RB+1:2]);
    offer(~r[RB-1:0]);
    @(negedge mclk_i);
    chk(40'(pos_ready_o), 40'h0, "ready while full");
    pos_valid_i = 1'h0;
    frame(r[RB-1:0], 1'h1);
    frame(r[RB+1:2], 1'h0);
    frame(r[RB+1:2], 1'h1);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      p = (i == 0) ? '0 : (i == 1) ? '1 : r[RB-1:0];
      offer(p);
      @(negedge mclk_i);
      pos_valid_i = 1'h0;
      frame(p, r[31]);
    end
    // A controller that stops after ten bits must still get an idle line back after the quiet time.
    m_u.read_frame(10, q, q2);
    chk(q, exp_frame(p, r[31]) >> (NB - 10), "cut frame");
    #27000;
    @(negedge mclk_i);
    chk(40'({link_data_o, frame_busy_o}), 40'h2, "idle after quiet");
    setup_mode_i = 1'h1;
    for (int i = 0; i < 4; i++) begin
      svc_tx_i = i[0];
      m_u.drive(i[1]);
      repeat (8) @(negedge mclk_i);
      chk({link_data_o, svc_rx_o}, {38'h0, i[0], i[1]}, "service pass");
    end
    m_u.drive(1'h1);
    setup_mode_i = 1'h0;
    r = $random(seed);
    offer(r[RB-1:0]);
    @(negedge mclk_i);
    pos_valid_i = 1'h0;
    frame(r[RB-1:0], 1'h1);
    report_and_stop();
  end

  // A hang is cut short well after the expected run of about 340 us.
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
endmodule
